// file: occ_output_compare_channel.sv
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
// How it works
// - Compare selected timer against compare registers
// - Select bit picks second timer when set
// - Mode 000: off, no interrupt, port owns pin
// - Mode 001: start low, match drives high
// - Mode 010: start high, match drives low
// - Mode 011: keep level, toggle every match
// - Mode 100: start low, single pulse, trailing interrupt
// - Mode 101: start low, repeating pulses, falling interrupts
// - Mode 110: PWM, fault ignored, no interrupt
// - Mode 111: PWM, fault falling edge interrupts
// - Fault A serves channels 1-4, B 5-8
// - Fault flag sets on fault, control write clears it once fault pin is high
// - Idle-stop bit halts channel in CPU Idle
// - Unimplemented control bits read as zero
module occ_output_compare_channel #(
   parameter int CHANNEL_NUM = 1,
   parameter int CMP_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [CMP_WIDTH-1:0] timerCountA,
   input wire logic [CMP_WIDTH-1:0] timerCountB,
   input wire logic timerTickA,
   input wire logic timerTickB,
   input wire logic [CMP_WIDTH-1:0] timerPeriodA,
   input wire logic [CMP_WIDTH-1:0] timerPeriodB,
   input wire logic nFaultInputA,
   input wire logic nFaultInputB,
   input wire logic cpuIdle,
   output logic compareOutputPin,
   output logic compareOutputEn,
   output logic compareEventPulse
);
   occ_regs_if rif ();

   occ_reg_slave u_regs (
      .mclk(mclk),
      .nrst(nrst),
      .address(avs_address),
      .read(avs_read),
      .write(avs_write),
      .writedata(avs_writedata),
      .byteenable(avs_byteenable),
      .readdata(avs_readdata),
      .waitrequest(avs_waitrequest),
      .rif(rif.regs)
   );

   logic pin;
   logic fltFlag;
   logic faultPrev;
   logic irq;
   occ_pkg::occ_pulse_t pulseState;
   logic next_pin;
   logic next_flt;
   occ_pkg::occ_pulse_t next_pulseState;

   // Time base selection
   wire [CMP_WIDTH-1:0] selCount = rif.timeSel ? timerCountB : timerCountA;
   wire selTick = rif.timeSel ? timerTickB : timerTickA;
   wire [CMP_WIDTH-1:0] selPeriod = rif.timeSel ? timerPeriodB : timerPeriodA;

   // Halted channel neither matches nor sees faults
   wire halted = rif.idleStop & cpuIdle;
   wire running = ~halted;

   // Matches are taken only on the tick where the count is new
   wire priMatch = running & selTick & (selCount == rif.primary[CMP_WIDTH-1:0]);
   wire secMatch = running & selTick & (selCount == rif.secondary[CMP_WIDTH-1:0]);
   wire perMatch = running & selTick & (selCount == selPeriod);

   // Fault pin shared by a group of channels
   wire faultIn = (CHANNEL_NUM <= occ_pkg::FAULT_A_LAST_CHANNEL) ? nFaultInputA : nFaultInputB;
   wire faultFall = faultPrev & ~faultIn;
   wire faultEvent = running & (rif.mode == occ_pkg::MODE_PWM_FAULT) & faultFall;

   wire modeOff = (rif.mode == occ_pkg::MODE_OFF);
   wire modePulse = (rif.mode == occ_pkg::MODE_ONE_PULSE) |
                    (rif.mode == occ_pkg::MODE_PULSE_TRAIN);
   wire modePwm = (rif.mode == occ_pkg::MODE_PWM) | (rif.mode == occ_pkg::MODE_PWM_FAULT);
   wire pwmStartLevel = (rif.primary != occ_pkg::CMP_RESET);

   always_comb
   begin
      next_pin = pin;
      next_pulseState = pulseState;
      next_flt = fltFlag;
      if (rif.ctrlLoaded)
      begin
         // Mode entry sets the initial pin level
         next_pulseState = occ_pkg::PS_WAIT_LEAD;
         case (rif.mode)
            occ_pkg::MODE_SET_HIGH: next_pin = 1'b0;
            occ_pkg::MODE_SET_LOW: next_pin = 1'b1;
            occ_pkg::MODE_TOGGLE: next_pin = pin;
            occ_pkg::MODE_ONE_PULSE: next_pin = 1'b0;
            occ_pkg::MODE_PULSE_TRAIN: next_pin = 1'b0;
            occ_pkg::MODE_PWM: next_pin = pwmStartLevel;
            occ_pkg::MODE_PWM_FAULT: next_pin = pwmStartLevel;
            default: next_pin = pin;
         endcase
         // Reconfiguring clears the flag once the fault pin is back high
         if (faultIn)
            next_flt = 1'b0;
      end
      else
      begin
         case (rif.mode)
            occ_pkg::MODE_SET_HIGH:
            begin
               if (priMatch)
                  next_pin = 1'b1;
            end
            occ_pkg::MODE_SET_LOW:
            begin
               if (priMatch)
                  next_pin = 1'b0;
            end
            occ_pkg::MODE_TOGGLE:
            begin
               if (priMatch)
                  next_pin = ~pin;
            end
            occ_pkg::MODE_ONE_PULSE, occ_pkg::MODE_PULSE_TRAIN:
            begin
               case (pulseState)
                  occ_pkg::PS_WAIT_LEAD:
                  begin
                     if (priMatch)
                     begin
                        next_pin = 1'b1;
                        next_pulseState = occ_pkg::PS_WAIT_TRAIL;
                     end
                  end
                  occ_pkg::PS_WAIT_TRAIL:
                  begin
                     if (secMatch)
                     begin
                        next_pin = 1'b0;
                        if (rif.mode == occ_pkg::MODE_PULSE_TRAIN)
                           next_pulseState = occ_pkg::PS_WAIT_LEAD;
                        else
                           next_pulseState = occ_pkg::PS_DONE;
                     end
                  end
                  occ_pkg::PS_DONE: next_pulseState = occ_pkg::PS_DONE;
                  default: next_pulseState = occ_pkg::PS_WAIT_LEAD;
               endcase
            end
            occ_pkg::MODE_PWM, occ_pkg::MODE_PWM_FAULT:
            begin
               // Period restart wins over a duty match in the same tick
               if (priMatch)
                  next_pin = 1'b0;
               if (perMatch)
                  next_pin = pwmStartLevel;
            end
            default: next_pin = pin;
         endcase
      end
      // Fault sets the flag and forces the safe level; set wins over clear
      if (faultEvent)
         next_flt = 1'b1;
      if (next_flt & (rif.mode == occ_pkg::MODE_PWM_FAULT))
         next_pin = 1'b0;
      // A stopped channel holds everything but register-driven entry
      if (halted & ~rif.ctrlLoaded)
      begin
         next_pin = pin;
         next_pulseState = pulseState;
      end
   end

   // Output edges that count as events, per mode
   wire pinRise = ~pin & next_pin & ~rif.ctrlLoaded;
   wire pinFall = pin & ~next_pin & ~rif.ctrlLoaded;
   wire next_irq = ((rif.mode == occ_pkg::MODE_SET_HIGH) & pinRise) |
                   ((rif.mode == occ_pkg::MODE_SET_LOW) & pinFall) |
                   ((rif.mode == occ_pkg::MODE_TOGGLE) & (pinRise | pinFall)) |
                   (modePulse & pinFall) |
                   faultEvent;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         pin <= 1'b0;
         fltFlag <= 1'b0;
         faultPrev <= 1'b1;
         irq <= 1'b0;
         pulseState <= occ_pkg::PS_WAIT_LEAD;
      end
      else
      begin
         pin <= next_pin;
         fltFlag <= next_flt;
         faultPrev <= faultIn;
         irq <= next_irq;
         pulseState <= next_pulseState;
      end
   end

   assign rif.fltFlag = fltFlag;
   // Disabled channel releases the pin to the port logic
   assign compareOutputEn = ~modeOff;
   assign compareOutputPin = pin;
   assign compareEventPulse = irq;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   off_quiet_a: assert property (
      modeOff && $past(modeOff) |-> !compareEventPulse && !compareOutputEn)
      else $error("Disabled channel drove pin or raised event");

   set_high_a: assert property (
      rif.mode == occ_pkg::MODE_SET_HIGH && !rif.ctrlLoaded && priMatch && !pin
      |=> compareOutputPin && compareEventPulse)
      else $error("Set-high match did not raise pin and event");

   set_low_a: assert property (
      rif.mode == occ_pkg::MODE_SET_LOW && !rif.ctrlLoaded && priMatch && pin
      |=> !compareOutputPin && compareEventPulse)
      else $error("Set-low match did not drop pin and event");

   toggle_flip_a: assert property (
      rif.mode == occ_pkg::MODE_TOGGLE && !rif.ctrlLoaded && priMatch
      |=> compareOutputPin != $past(compareOutputPin) && compareEventPulse)
      else $error("Toggle match did not invert pin");

   entry_low_a: assert property (
      rif.ctrlLoaded && (rif.mode == occ_pkg::MODE_SET_HIGH || modePulse)
      |=> !compareOutputPin && !compareEventPulse)
      else $error("Mode entry did not start pin low");

   pulse_end_a: assert property (
      rif.mode == occ_pkg::MODE_ONE_PULSE && pulseState == occ_pkg::PS_WAIT_TRAIL
      && secMatch && !rif.ctrlLoaded
      |=> !compareOutputPin && compareEventPulse && pulseState == occ_pkg::PS_DONE)
      else $error("Single pulse did not end on secondary match");

   train_rearm_a: assert property (
      rif.mode == occ_pkg::MODE_PULSE_TRAIN && pulseState == occ_pkg::PS_WAIT_TRAIL
      && secMatch && !rif.ctrlLoaded && !halted
      |=> pulseState == occ_pkg::PS_WAIT_LEAD && compareEventPulse)
      else $error("Pulse train did not rearm");

   pwm_entry_a: assert property (
      rif.ctrlLoaded && modePwm && !fltFlag && !faultEvent
      |=> compareOutputPin == ($past(rif.primary) != occ_pkg::CMP_RESET))
      else $error("PWM entry level wrong");

   pwm_silent_a: assert property (
      rif.mode == occ_pkg::MODE_PWM && $past(rif.mode) == occ_pkg::MODE_PWM
      && !$past(rif.ctrlLoaded) |-> !compareEventPulse)
      else $error("Plain PWM raised an event");

   fault_event_a: assert property (
      faultEvent |=> compareEventPulse && fltFlag && !compareOutputPin)
      else $error("Fault edge not reported");

   fault_safe_a: assert property (
      fltFlag && rif.mode == occ_pkg::MODE_PWM_FAULT && !rif.ctrlLoaded |-> !compareOutputPin)
      else $error("Output active during fault");

   flag_hold_a: assert property (
      fltFlag && !rif.ctrlLoaded |=> fltFlag)
      else $error("Fault flag cleared without reconfiguration");

   halt_hold_a: assert property (
      halted && !rif.ctrlLoaded && !faultEvent |=> $stable(compareOutputPin))
      else $error("Halted channel changed its pin");

   timer_b_a: assert property (
      rif.timeSel && rif.mode == occ_pkg::MODE_SET_HIGH && !rif.ctrlLoaded && running
      && timerTickB && timerCountB == rif.primary && !pin |=> compareOutputPin)
      else $error("Second time base not compared");

   entry_high_a: assert property (
      rif.ctrlLoaded && rif.mode == occ_pkg::MODE_SET_LOW
      |=> compareOutputPin && !compareEventPulse)
      else $error("Set-low entry did not start pin high");

   toggle_entry_a: assert property (
      rif.ctrlLoaded && rif.mode == occ_pkg::MODE_TOGGLE
      |=> $stable(compareOutputPin) && !compareEventPulse)
      else $error("Toggle entry changed the pin");

   no_match_a: assert property (
      (rif.mode == occ_pkg::MODE_SET_HIGH || rif.mode == occ_pkg::MODE_SET_LOW
      || rif.mode == occ_pkg::MODE_TOGGLE) && !rif.ctrlLoaded && !priMatch
      |=> $stable(compareOutputPin) && !compareEventPulse)
      else $error("Pin moved without a compare match");

   pulse_lead_a: assert property (
      modePulse && pulseState == occ_pkg::PS_WAIT_LEAD && priMatch && !rif.ctrlLoaded
      |=> compareOutputPin && pulseState == occ_pkg::PS_WAIT_TRAIL && !compareEventPulse)
      else $error("Pulse did not start on primary match");

   single_done_a: assert property (
      rif.mode == occ_pkg::MODE_ONE_PULSE && pulseState == occ_pkg::PS_DONE
      && !rif.ctrlLoaded |=> pulseState == occ_pkg::PS_DONE && $stable(compareOutputPin))
      else $error("Single pulse mode fired again");

   train_wait_a: assert property (
      rif.mode == occ_pkg::MODE_PULSE_TRAIN && pulseState == occ_pkg::PS_WAIT_LEAD
      && !priMatch && !rif.ctrlLoaded |=> $stable(compareOutputPin) && !compareEventPulse)
      else $error("Pulse train moved before primary match");

   pwm_duty_a: assert property (
      modePwm && !rif.ctrlLoaded && priMatch && !perMatch |=> !compareOutputPin)
      else $error("PWM duty match did not drop pin");

   pwm_period_a: assert property (
      rif.mode == occ_pkg::MODE_PWM && !rif.ctrlLoaded && perMatch
      |=> compareOutputPin == ($past(rif.primary) != occ_pkg::CMP_RESET))
      else $error("PWM period restart level wrong");

   pwm_no_fault_a: assert property (
      rif.mode == occ_pkg::MODE_PWM && !fltFlag |=> !fltFlag)
      else $error("Plain PWM recorded a fault");

   flag_quiet_a: assert property (
      !fltFlag && !faultEvent |=> !fltFlag)
      else $error("Fault flag set without a fault");

   group_a_fault_a: assert property (
      CHANNEL_NUM <= occ_pkg::FAULT_A_LAST_CHANNEL && $fell(nFaultInputA) && running
      && rif.mode == occ_pkg::MODE_PWM_FAULT |=> fltFlag && compareEventPulse)
      else $error("Fault input A not honoured");

   other_group_a: assert property (
      CHANNEL_NUM <= occ_pkg::FAULT_A_LAST_CHANNEL && !fltFlag && nFaultInputA
      && $past(nFaultInputA) |=> !fltFlag)
      else $error("Fault input of other group was honoured");

   idle_run_a: assert property (
      !rif.idleStop && cpuIdle && rif.mode == occ_pkg::MODE_SET_LOW && !rif.ctrlLoaded
      && selTick && selCount == rif.primary[CMP_WIDTH-1:0] |=> !compareOutputPin)
      else $error("Channel stopped in Idle with stop bit clear");
endmodule

// file: occ_pkg.sv
package occ_pkg;
   // Register byte offsets on the Avalon slave
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PRIMARY = 4'h4;
   localparam logic [3:0] ADDR_SECONDARY = 4'h8;

   // Control register field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MODE_MSB = 2;
   localparam int CTRL_TSEL_BIT = 3;
   localparam int CTRL_FLT_BIT = 4;
   localparam int CTRL_IDLE_BIT = 13;
   localparam logic [15:0] CTRL_READ_MASK = 16'h201F;

   // Reset values
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // Compare mode field codes
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_SET_HIGH = 3'h1;
   localparam logic [2:0] MODE_SET_LOW = 3'h2;
   localparam logic [2:0] MODE_TOGGLE = 3'h3;
   localparam logic [2:0] MODE_ONE_PULSE = 3'h4;
   localparam logic [2:0] MODE_PULSE_TRAIN = 3'h5;
   localparam logic [2:0] MODE_PWM = 3'h6;
   localparam logic [2:0] MODE_PWM_FAULT = 3'h7;

   // Channels up to this number use fault input A, the rest input B
   localparam int FAULT_A_LAST_CHANNEL = 4;

   typedef enum logic [1:0] {PS_WAIT_LEAD, PS_WAIT_TRAIL, PS_DONE} occ_pulse_t;
endpackage

// file: occ_regs_if.sv
`timescale 1ns/10ps
interface occ_regs_if;
   logic [2:0] mode;
   logic timeSel;
   logic idleStop;
   logic [15:0] primary;
   logic [15:0] secondary;
   logic ctrlLoaded;
   logic fltFlag;

   modport regs (
      output mode,
      output timeSel,
      output idleStop,
      output primary,
      output secondary,
      output ctrlLoaded,
      input fltFlag
   );
   modport core (
      input mode,
      input timeSel,
      input idleStop,
      input primary,
      input secondary,
      input ctrlLoaded,
      output fltFlag
   );
endinterface

// file: occ_reg_slave.sv
`timescale 1ns/10ps
module occ_reg_slave (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   occ_regs_if.regs rif
);
   logic ack;
   logic [2:0] mode;
   logic timeSel;
   logic idleStop;
   logic [15:0] primary;
   logic [15:0] secondary;
   logic ctrlLoaded;

   // One wait state: request seen, then answered at the next edge
   wire request = read | write;
   wire accept = request & ~ack;
   wire doWrite = write & ack;
   wire selCtrl = (address == occ_pkg::ADDR_CTRL);
   wire selPri = (address == occ_pkg::ADDR_PRIMARY);
   wire selSec = (address == occ_pkg::ADDR_SECONDARY);
   wire [15:0] ctrlView = {2'h0, idleStop, 8'h00, rif.fltFlag, timeSel, mode};
   wire [31:0] readMux = selCtrl ? {16'h0000, ctrlView} :
                         selPri ? {16'h0000, primary} :
                         selSec ? {16'h0000, secondary} : occ_pkg::UNMAPPED_READ;
   wire [15:0] laneMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   wire [15:0] nextPri = (primary & ~laneMask) | (writedata[15:0] & laneMask);
   wire [15:0] nextSec = (secondary & ~laneMask) | (writedata[15:0] & laneMask);

   assign waitrequest = request & ~ack;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         ack <= 1'b0;
         readdata <= occ_pkg::UNMAPPED_READ;
         mode <= occ_pkg::MODE_RESET;
         timeSel <= 1'b0;
         idleStop <= 1'b0;
         primary <= occ_pkg::CMP_RESET;
         secondary <= occ_pkg::CMP_RESET;
         ctrlLoaded <= 1'b0;
      end
      else
      begin
         ack <= accept;
         ctrlLoaded <= doWrite & selCtrl;
         if (accept & read)
            readdata <= readMux;
         // Fault flag bit is not writable; hardware owns it
         if (doWrite & selCtrl & byteenable[0])
         begin
            mode <= writedata[occ_pkg::CTRL_MODE_MSB:occ_pkg::CTRL_MODE_LSB];
            timeSel <= writedata[occ_pkg::CTRL_TSEL_BIT];
         end
         if (doWrite & selCtrl & byteenable[1])
            idleStop <= writedata[occ_pkg::CTRL_IDLE_BIT];
         if (doWrite & selPri)
            primary <= nextPri;
         if (doWrite & selSec)
            secondary <= nextSec;
      end
   end

   assign rif.mode = mode;
   assign rif.timeSel = timeSel;
   assign rif.idleStop = idleStop;
   assign rif.primary = primary;
   assign rif.secondary = secondary;
   assign rif.ctrlLoaded = ctrlLoaded;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   reserved_zero_a: assert property (ack && read && selCtrl |-> (readdata[15:0] & ~occ_pkg::CTRL_READ_MASK) == 16'h0000 && readdata[31:16] == 16'h0000)
      else $error("Unimplemented control bits read nonzero");
   flag_readback_a: assert property (accept && read && selCtrl |=> readdata[occ_pkg::CTRL_FLT_BIT] == $past(rif.fltFlag))
      else $error("Fault flag readback mismatch");
endmodule

// file: occ_pin_load.sv
`timescale 1ns/10ps
module occ_pin_load (
   input wire logic pinOut,
   input wire logic pinEn,
   output logic lineLevel
);
   // Board pull-down: a released pin reads low, never the last driven level
   assign lineLevel = pinEn ? pinOut : 1'b0;
endmodule

// file: occ_output_compare_channel_tb.sv
`timescale 1ns/10ps
module occ_output_compare_channel_tb;
   localparam logic [3:0] ACTRL = occ_pkg::ADDR_CTRL;
   localparam logic [3:0] APRIM = occ_pkg::ADDR_PRIMARY;
   localparam logic [3:0] ASEC = occ_pkg::ADDR_SECONDARY;
   logic mclk;
   logic nrst;
   logic [3:0] avsAddress;
   logic avsRead;
   logic avsWrite;
   logic [31:0] avsWritedata;
   logic [3:0] avsByteenable;
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   logic [15:0] countA, countB, periodA, periodB, prim, sec, per;
   logic tickA, tickB, nFaultA, nFaultB, cpuIdle;
   logic pinOut, pinEn, eventPulse, lineLevel, probe;
   logic [7:0] evCount = 8'h00;
   logic [31:0] expQ[$];
   string nameQ[$];
   int numErrors, checkCount, seed, ev;

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   occ_output_compare_channel #(.CHANNEL_NUM(1), .CMP_WIDTH(16)) uut (
      .mclk(mclk), .nrst(nrst), .avs_address(avsAddress), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .timerCountA(countA), .timerCountB(countB), .timerTickA(tickA), .timerTickB(tickB),
      .timerPeriodA(periodA), .timerPeriodB(periodB), .nFaultInputA(nFaultA),
      .nFaultInputB(nFaultB), .cpuIdle(cpuIdle), .compareOutputPin(pinOut),
      .compareOutputEn(pinEn), .compareEventPulse(eventPulse)
   );

   occ_pin_load load (.pinOut(pinOut), .pinEn(pinEn), .lineLevel(lineLevel));

   task automatic results();
      if (numErrors == 0 && checkCount > 0 && expQ.size() == 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic expect_val(input string name, input logic [31:0] value);
      expQ.push_back(value);
      nameQ.push_back(name);
   endtask

   task automatic compare(input logic [31:0] seen);
      logic [31:0] want;
      string name;
      checkCount++;
      if (expQ.size() == 0)
      begin
         numErrors++;
         $display("MISMATCH result expected none seen %h", seen);
      end
      else
      begin
         want = expQ.pop_front();
         name = nameQ.pop_front();
         if (seen !== want)
         begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", name, want, seen);
         end
      end
   endtask

   // The slave answers after one wait state; the bound only catches a hang
   task automatic wait_ack();
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avsWaitrequest !== 1'b0 && n < 20);
      if (avsWaitrequest !== 1'b0)
      begin
         numErrors++;
         $display("MISMATCH waitrequest expected 0 seen %b", avsWaitrequest);
      end
   endtask

   task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      avsAddress <= a;
      avsWritedata <= d;
      avsByteenable <= be;
      avsWrite <= 1'b1;
      wait_ack();
      avsWrite <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic bus_read(input logic [3:0] a, input string name, input logic [31:0] value);
      expect_val(name, value);
      avsAddress <= a;
      avsRead <= 1'b1;
      wait_ack();
      avsRead <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic probe_chk(input string name, input logic en, input logic lvl);
      expect_val(name, {22'h0, ev[7:0], en, lvl});
      probe <= 1'b1;
      @(posedge mclk);
      probe <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic tick(input logic sel, input logic [15:0] value);
      if (sel)
      begin
         countB <= value;
         tickB <= 1'b1;
      end
      else
      begin
         countA <= value;
         tickA <= 1'b1;
      end
      @(posedge mclk);
      tickA <= 1'b0;
      tickB <= 1'b0;
      @(posedge mclk);
   endtask

   always @(posedge mclk)
   begin
      if (eventPulse === 1'b1)
         evCount <= evCount + 8'h01;
   end

   always @(posedge mclk)
   begin
      if (avsRead === 1'b1 && avsWaitrequest === 1'b0)
         compare(avsReaddata);
      else if (probe === 1'b1)
         compare({22'h0, evCount, pinEn, lineLevel});
   end

   initial
   begin
      repeat (5000) @(posedge mclk);
      numErrors++;
      results();
   end

   initial
   begin
      seed = 32'h861774AB;
      nrst = 1'b0;
      {avsAddress, avsRead, avsWrite, avsWritedata, avsByteenable} = '0;
      {countA, countB, tickA, tickB, cpuIdle, probe} = '0;
      nFaultA = 1'b1;
      nFaultB = 1'b1;
      ev = 0;
      prim = {1'b0, 15'($random(seed))} | 16'h0100;
      sec = prim + 16'h0010;
      per = prim + 16'h0100;
      periodA = per;
      periodB = per;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      bus_read(ACTRL, "ctrl", 32'h0);
      bus_read(APRIM, "primary", 32'h0);
      probe_chk("reset", 1'b0, 1'b0);
      bus_write(ACTRL, 32'hFFFF_FFFF, 4'hF);
      bus_read(ACTRL, "ctrl", 32'h0000_200F);
      bus_write(ACTRL, 32'h0, 4'h2);
      bus_read(ACTRL, "ctrl", 32'h0000_000F);
      bus_write(4'hC, 32'hFFFF_FFFF, 4'hF);
      bus_read(4'hC, "unmapped", 32'h0);
      bus_write(APRIM, {16'h0, prim}, 4'hF);
      bus_write(ASEC, {16'h0, sec}, 4'hF);
      bus_read(APRIM, "primary", {16'h0, prim});
      bus_read(ASEC, "secondary", {16'h0, sec});
      bus_write(ACTRL, 32'h1, 4'hF);
      probe_chk("m1 entry", 1'b1, 1'b0);
      tick(1'b0, prim ^ 16'h8000);
      tick(1'b1, prim);
      probe_chk("m1 wrong timer", 1'b1, 1'b0);
      tick(1'b0, prim);
      ev++;
      probe_chk("m1 match", 1'b1, 1'b1);
      bus_write(ACTRL, 32'h3, 4'hF);
      probe_chk("m3 entry", 1'b1, 1'b1);
      for (int i = 0; i < 2; i++)
      begin
         tick(1'b0, prim);
         ev++;
         probe_chk("m3 toggle", 1'b1, i[0]);
      end
      bus_write(ACTRL, 32'hA, 4'hF);
      probe_chk("m2 entry", 1'b1, 1'b1);
      tick(1'b0, prim);
      probe_chk("m2 timer a", 1'b1, 1'b1);
      tick(1'b1, prim);
      ev++;
      probe_chk("m2 match", 1'b1, 1'b0);
      bus_write(ACTRL, 32'h4, 4'hF);
      tick(1'b0, prim);
      probe_chk("m4 lead", 1'b1, 1'b1);
      tick(1'b0, sec);
      ev++;
      probe_chk("m4 trail", 1'b1, 1'b0);
      tick(1'b0, prim);
      probe_chk("m4 single", 1'b1, 1'b0);
      bus_write(ACTRL, 32'h5, 4'hF);
      for (int i = 0; i < 2; i++)
      begin
         tick(1'b0, prim);
         probe_chk("m5 lead", 1'b1, 1'b1);
         tick(1'b0, sec);
         ev++;
         probe_chk("m5 trail", 1'b1, 1'b0);
      end
      bus_write(ACTRL, 32'h6, 4'hF);
      probe_chk("m6 entry", 1'b1, 1'b1);
      nFaultA <= 1'b0;
      tick(1'b0, prim);
      probe_chk("m6 duty", 1'b1, 1'b0);
      tick(1'b0, per);
      probe_chk("m6 period", 1'b1, 1'b1);
      nFaultA <= 1'b1;
      @(posedge mclk);
      bus_write(ACTRL, 32'h7, 4'hF);
      nFaultB <= 1'b0;
      repeat (2) @(posedge mclk);
      probe_chk("m7 fault b", 1'b1, 1'b1);
      nFaultB <= 1'b1;
      nFaultA <= 1'b0;
      repeat (2) @(posedge mclk);
      ev++;
      probe_chk("m7 fault", 1'b1, 1'b0);
      bus_read(ACTRL, "ctrl flag", 32'h0000_0017);
      tick(1'b0, per);
      probe_chk("m7 forced", 1'b1, 1'b0);
      bus_write(ACTRL, 32'h7, 4'hF);
      bus_read(ACTRL, "ctrl flag", 32'h0000_0017);
      nFaultA <= 1'b1;
      @(posedge mclk);
      bus_write(ACTRL, 32'h7, 4'hF);
      bus_read(ACTRL, "ctrl flag", 32'h0000_0007);
      bus_write(ACTRL, 32'h2001, 4'hF);
      cpuIdle <= 1'b1;
      tick(1'b0, prim);
      probe_chk("idle halt", 1'b1, 1'b0);
      cpuIdle <= 1'b0;
      tick(1'b0, prim);
      ev++;
      probe_chk("idle resume", 1'b1, 1'b1);
      bus_write(ACTRL, 32'h2, 4'hF);
      cpuIdle <= 1'b1;
      tick(1'b0, prim);
      ev++;
      probe_chk("idle run", 1'b1, 1'b0);
      cpuIdle <= 1'b0;
      bus_write(ACTRL, 32'h0, 4'hF);
      tick(1'b0, prim);
      tick(1'b1, prim);
      probe_chk("m0 off", 1'b0, 1'b0);
      repeat (4) @(posedge mclk);
      results();
   end
endmodule
